/* File: hdl/orsc_pkg.sv */
// Types shared by the oscillator run/stop control
package orsc_pkg;

	typedef enum logic [2:0] {
		ORSC_ST_HALTED  = 3'b001,
		ORSC_ST_SETTLE  = 3'b010,
		ORSC_ST_STABLE  = 3'b100
	} orsc_stab_state_t;

endpackage

/* File: hdl/orsc_regs.svh */
// Register offsets, field positions, reset values and timing for oscillator control
`ifndef ORSC_REGS_SVH
`define ORSC_REGS_SVH

`define ORSC_ADDR_W              16
`define ORSC_ADDR_INT_OSC_MODE   16'hFFA0
`define ORSC_ADDR_MAIN_OSC_CTRL  16'hFFA2

`define ORSC_BIT_HS_STABLE       7
`define ORSC_BIT_LS_HALT         1
`define ORSC_BIT_HS_HALT         0
`define ORSC_BIT_SRC_HALT        7

`define ORSC_RST_INT_OSC_MODE    8'h00
`define ORSC_SET_INT_OSC_MODE    8'h80
`define ORSC_RST_MAIN_OSC_CTRL   8'h80
`define ORSC_READ_UNMAPPED       8'h00

// Settling time of the internal high-speed oscillator, and clock period
`define ORSC_HS_SETTLE_NS        10000
`define ORSC_CLK_PERIOD_NS       4

`endif

/* File: hdl/orsc_run_stop_ctrl.sv */
// Oscillator run/stop control registers and clock source enables
//
// Operation
// - The oscillator mode register reads 00H after reset and becomes 80H once the internal fast oscillator has settled.
// - Bit 7 of the oscillator mode register is a read-only flag showing whether the internal fast oscillator is stable.
// - Bit 1 of the oscillator mode register stops the internal slow oscillator when 1 and lets it run when 0.
// - Bit 0 of the oscillator mode register stops the internal fast oscillator when 1 and lets it run when 0.
// - With the source halt bit at 1 the crystal oscillator stops, or in external mode the clock input is blocked.
// - With the source halt bit at 0 the crystal oscillator runs, or in external mode the clock input is accepted.
// - Peripherals whose clock is stopped cease operating and need reinitialising after their clock returns.
// - Reset loads the main oscillator control register with 80H so the system clock source starts halted.
`timescale 1ns/1ps
`include "orsc_regs.svh"
module orsc_run_stop_ctrl
	import orsc_pkg::*;
#(
	parameter int SETTLE_NS = `ORSC_HS_SETTLE_NS
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    srst_i,
	// CPU register access
	input  wire logic [`ORSC_ADDR_W-1:0] cpu_addr_i,
	input  wire logic                    cpu_wr_i,
	input  wire logic                    cpu_rd_i,
	input  wire logic [7:0]              cpu_wdata_i,
	output logic      [7:0]              cpu_rdata_o,
	// Oscillator pin mode: 1 when an external clock drives the pins
	input  wire logic                    ext_clk_mode_i,
	// Oscillator controls
	output logic                         hs_internal_osc_halt_o,
	output logic                         low_speed_osc_halt_o,
	output logic                         crystal_oscillator_halt_o,
	output logic                         external_clock_input_en_o,
	output logic                         hs_osc_stable_flag_o,
	// Peripheral clock enables
	output logic                         hs_int_periph_clk_en_o,
	output logic                         hs_sys_periph_clk_en_o
);

	localparam int SETTLE_CYC = (SETTLE_NS + `ORSC_CLK_PERIOD_NS - 1) / `ORSC_CLK_PERIOD_NS;
	localparam int SETTLE_W   = $clog2(SETTLE_CYC + 1);
	localparam logic [7:0] CTRL_RST = `ORSC_RST_MAIN_OSC_CTRL;

	logic       hs_internal_osc_halt;
	logic       low_speed_osc_halt;
	logic       system_clock_source_halt;
	logic       hs_osc_stable_flag;
	logic [7:0] internal_osc_mode;
	logic [7:0] main_osc_control;
	logic       wr_int_osc_mode;
	logic       wr_main_osc_ctrl;

	assign wr_int_osc_mode  = cpu_wr_i && (cpu_addr_i == `ORSC_ADDR_INT_OSC_MODE);
	assign wr_main_osc_ctrl = cpu_wr_i && (cpu_addr_i == `ORSC_ADDR_MAIN_OSC_CTRL);

	// Stop bits of the internal oscillators
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hs_internal_osc_halt <= 1'b0;
			low_speed_osc_halt   <= 1'b0;
		end else if (wr_int_osc_mode) begin
			low_speed_osc_halt   <= cpu_wdata_i[`ORSC_BIT_LS_HALT];
			hs_internal_osc_halt <= cpu_wdata_i[`ORSC_BIT_HS_HALT];
		end
	end

	// System clock source halt, starts halted
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			system_clock_source_halt <= CTRL_RST[`ORSC_BIT_SRC_HALT];
		end else if (wr_main_osc_ctrl) begin
			system_clock_source_halt <= cpu_wdata_i[`ORSC_BIT_SRC_HALT];
		end
	end

	// Status is owned by the timer; CPU writes to bit 7 have no path here
	orsc_stab_timer #(
		.CNT_W      (SETTLE_W),
		.SETTLE_CYC (SETTLE_CYC)
	) u_stab (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.osc_run_i (!hs_internal_osc_halt),
		.stable_o  (hs_osc_stable_flag)
	);

	// Unused bit positions are tied to zero
	always_comb begin
		internal_osc_mode = 8'h00;
		internal_osc_mode[`ORSC_BIT_HS_STABLE] = hs_osc_stable_flag;
		internal_osc_mode[`ORSC_BIT_LS_HALT]   = low_speed_osc_halt;
		internal_osc_mode[`ORSC_BIT_HS_HALT]   = hs_internal_osc_halt;
		main_osc_control = 8'h00;
		main_osc_control[`ORSC_BIT_SRC_HALT]   = system_clock_source_halt;
	end

	// Read data one cycle after the strobe; held otherwise
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cpu_rdata_o <= `ORSC_READ_UNMAPPED;
		end else if (cpu_rd_i) begin
			case (cpu_addr_i)
				`ORSC_ADDR_INT_OSC_MODE:  cpu_rdata_o <= internal_osc_mode;
				`ORSC_ADDR_MAIN_OSC_CTRL: cpu_rdata_o <= main_osc_control;
				default:                  cpu_rdata_o <= `ORSC_READ_UNMAPPED;
			endcase
		end
	end

	// Oscillator controls, registered so the analog side sees clean levels
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hs_internal_osc_halt_o    <= 1'b0;
			low_speed_osc_halt_o      <= 1'b0;
			crystal_oscillator_halt_o <= 1'b1;
			external_clock_input_en_o <= 1'b0;
			hs_osc_stable_flag_o      <= 1'b0;
		end else begin
			hs_internal_osc_halt_o    <= hs_internal_osc_halt;
			low_speed_osc_halt_o      <= low_speed_osc_halt;
			crystal_oscillator_halt_o <= system_clock_source_halt || ext_clk_mode_i;
			external_clock_input_en_o <= !system_clock_source_halt && ext_clk_mode_i;
			hs_osc_stable_flag_o      <= hs_osc_stable_flag;
		end
	end

	// Fast-clock peripherals are held idle while unsettled or stopped, system-clock peripherals while the source is halted
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hs_int_periph_clk_en_o <= 1'b0;
			hs_sys_periph_clk_en_o <= 1'b0;
		end else begin
			hs_int_periph_clk_en_o <= hs_osc_stable_flag && !hs_internal_osc_halt;
			hs_sys_periph_clk_en_o <= !system_clock_source_halt;
		end
	end

	// Helper: cycles the fast oscillator has run without a stop
	logic [SETTLE_W-1:0] run_cnt;
	always_ff @(posedge clk_i) begin
		if (srst_i || hs_internal_osc_halt) begin
			run_cnt <= '0;
		end else if (run_cnt != SETTLE_W'(SETTLE_CYC)) begin
			run_cnt <= run_cnt + SETTLE_W'(1);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_mode_write;
		wr_int_osc_mode;
	endsequence

	sequence s_ctrl_write;
		wr_main_osc_ctrl;
	endsequence

	sequence s_mode_read;
		cpu_rd_i && cpu_addr_i == `ORSC_ADDR_INT_OSC_MODE;
	endsequence

	sequence s_ctrl_read;
		cpu_rd_i && cpu_addr_i == `ORSC_ADDR_MAIN_OSC_CTRL;
	endsequence

	sequence s_settle_done;
		!hs_internal_osc_halt && run_cnt == SETTLE_W'(SETTLE_CYC - 1);
	endsequence

	a_reset_mode_zero: assert property (disable iff (1'b0) $fell(srst_i) |-> internal_osc_mode == 8'h00)
		else $error("mode register not 00H after reset");
	a_settle_exact: assert property (hs_osc_stable_flag
		== (!hs_internal_osc_halt && run_cnt == SETTLE_W'(SETTLE_CYC)))
		else $error("stable flag not tied to settle time");
	a_stable_reads_80: assert property ((hs_osc_stable_flag && internal_osc_mode[1:0] == 2'b00)
		|-> internal_osc_mode == `ORSC_SET_INT_OSC_MODE)
		else $error("settled mode register not 80H");
	a_status_readback: assert property (s_mode_read |=> cpu_rdata_o[7] == $past(hs_osc_stable_flag))
		else $error("status bit readback wrong");
	a_stop_drops_stable: assert property (hs_internal_osc_halt |-> !hs_osc_stable_flag ##1 !hs_osc_stable_flag_o)
		else $error("stable flag set while stopped");
	a_ls_halt_write: assert property (s_mode_write |=> low_speed_osc_halt == $past(cpu_wdata_i[1])
		##1 low_speed_osc_halt_o == $past(cpu_wdata_i[1], 2))
		else $error("slow oscillator stop not taken");
	a_hs_halt_write: assert property (s_mode_write |=> hs_internal_osc_halt == $past(cpu_wdata_i[0])
		##1 hs_internal_osc_halt_o == $past(cpu_wdata_i[0], 2))
		else $error("fast oscillator stop not taken");
	a_src_halt_out: assert property (s_ctrl_write ##1 !ext_clk_mode_i
		|=> crystal_oscillator_halt_o == $past(cpu_wdata_i[7], 2) && !external_clock_input_en_o)
		else $error("crystal halt not following control bit");
	a_ext_gate_out: assert property (s_ctrl_write ##1 ext_clk_mode_i
		|=> external_clock_input_en_o == !$past(cpu_wdata_i[7], 2))
		else $error("external clock gate not following control bit");
	a_ctrl_reset_80: assert property (disable iff (1'b0) srst_i |=> main_osc_control == `ORSC_RST_MAIN_OSC_CTRL)
		else $error("control register not 80H after reset");
	a_unused_zero: assert property (cpu_rd_i |=> cpu_rdata_o[6:2] == 5'b00000)
		else $error("unused bits read nonzero");
	a_periph_stop: assert property (system_clock_source_halt |=> !hs_sys_periph_clk_en_o)
		else $error("peripheral clock left on after stop");
	a_settle_rise: assert property (s_settle_done ##1 !hs_internal_osc_halt
		|-> hs_osc_stable_flag ##1 hs_osc_stable_flag_o)
		else $error("stable flag late after settle time");
	a_int_periph_stop: assert property (hs_internal_osc_halt |=> !hs_int_periph_clk_en_o)
		else $error("fast peripheral clock left on after stop");
	a_unmapped_zero: assert property (cpu_rd_i && cpu_addr_i != `ORSC_ADDR_INT_OSC_MODE
		&& cpu_addr_i != `ORSC_ADDR_MAIN_OSC_CTRL |=> cpu_rdata_o == `ORSC_READ_UNMAPPED)
		else $error("unmapped read nonzero");
	a_ctrl_readback: assert property (s_ctrl_read |=> cpu_rdata_o == $past(main_osc_control))
		else $error("control register readback wrong");
	a_ext_crystal_off: assert property (ext_clk_mode_i |=> crystal_oscillator_halt_o)
		else $error("crystal running in external mode");
	a_xtal_no_ext: assert property (!ext_clk_mode_i |=> !external_clock_input_en_o)
		else $error("external input open in crystal mode");

endmodule // orsc_run_stop_ctrl

/* File: hdl/orsc_stab_timer.sv */
// Stabilisation timer for the internal high-speed oscillator
`timescale 1ns/1ps
module orsc_stab_timer
	import orsc_pkg::*;
#(
	parameter int CNT_W       = 12,
	parameter int SETTLE_CYC  = 2500
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// Oscillator state
	input  wire logic osc_run_i,
	output logic      stable_o
);

	localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYC - 1);

	orsc_stab_state_t state;
	logic [CNT_W-1:0] count;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= ORSC_ST_SETTLE;
		end else begin
			case (state)
				ORSC_ST_HALTED: begin
					if (osc_run_i && count == LAST) begin
						state <= ORSC_ST_STABLE;
					end else if (osc_run_i) begin
						state <= ORSC_ST_SETTLE;
					end
				end
				ORSC_ST_SETTLE: begin
					if (!osc_run_i) begin
						state <= ORSC_ST_HALTED;
					end else if (count == LAST) begin
						state <= ORSC_ST_STABLE;
					end
				end
				ORSC_ST_STABLE: begin
					if (!osc_run_i) begin
						state <= ORSC_ST_HALTED;
					end
				end
				default: begin
					state <= ORSC_ST_HALTED;
				end
			endcase
		end
	end

	// Count every running cycle from the restart, so a halt costs a full settle
	always_ff @(posedge clk_i) begin
		if (srst_i || state == ORSC_ST_STABLE || !osc_run_i) begin
			count <= '0;
		end else begin
			count <= count + CNT_W'(1);
		end
	end

	// Status drops in the same cycle the stop bit is set
	assign stable_o = (state == ORSC_ST_STABLE) && osc_run_i;

endmodule // orsc_stab_timer

/* File: test/orsc_run_stop_ctrl_tb.sv */
// Self-checking testbench for the oscillator run/stop control registers
`timescale 1ns/1ps
`include "orsc_regs.svh"
module orsc_run_stop_ctrl_tb;
	import orsc_pkg::*;
	logic        clk_i          = 1'b0;
	logic        srst_i         = 1'b1;
	logic [15:0] cpu_addr_i     = 16'h0000;
	logic        cpu_wr_i       = 1'b0;
	logic        cpu_rd_i       = 1'b0;
	logic [7:0]  cpu_wdata_i    = 8'h00;
	logic        ext_clk_mode_i = 1'b0;
	logic [7:0]  cpu_rdata_o;
	logic        hs_halt, ls_halt, xtal_halt, ext_en, stable, int_en, sys_en;
	logic [7:0]  exp_q[$];
	logic        rd_q           = 1'b0;
	int          fails          = 0;
	int          total_checks   = 0;
	logic        m_hs           = 1'b0;
	logic        m_ls           = 1'b0;
	logic        m_ms           = 1'b1;
	logic        m_st           = 1'b0;

	// Short settle time keeps the run brief
	orsc_run_stop_ctrl #(.SETTLE_NS(40)) uut (
		.clk_i                     (clk_i),
		.srst_i                    (srst_i),
		.cpu_addr_i                (cpu_addr_i),
		.cpu_wr_i                  (cpu_wr_i),
		.cpu_rd_i                  (cpu_rd_i),
		.cpu_wdata_i               (cpu_wdata_i),
		.cpu_rdata_o               (cpu_rdata_o),
		.ext_clk_mode_i            (ext_clk_mode_i),
		.hs_internal_osc_halt_o    (hs_halt),
		.low_speed_osc_halt_o      (ls_halt),
		.crystal_oscillator_halt_o (xtal_halt),
		.external_clock_input_en_o (ext_en),
		.hs_osc_stable_flag_o      (stable),
		.hs_int_periph_clk_en_o    (int_en),
		.hs_sys_periph_clk_en_o    (sys_en)
	);

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cpu_addr_i  <= a;
		cpu_wdata_i <= d;
		cpu_wr_i    <= 1'b1;
		@(posedge clk_i);
		cpu_wr_i    <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_i);
		exp_q.push_back(e);
		cpu_addr_i <= a;
		cpu_rd_i   <= 1'b1;
		@(posedge clk_i);
		cpu_rd_i   <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	// External mode forces the crystal off; the input path opens only with the source halt bit at 0
	task automatic chk_out;
		@(negedge clk_i);
		check({1'b0, hs_halt, ls_halt, xtal_halt, ext_en, stable, int_en, sys_en},
			{1'b0, m_hs, m_ls, ext_clk_mode_i | m_ms, ext_clk_mode_i & ~m_ms,
			m_st, m_st & ~m_hs, ~m_ms});
	endtask

	// Read data is registered, so it is judged one cycle after the strobe
	always @(posedge clk_i) begin
		rd_q <= cpu_rd_i;
	end

	always @(negedge clk_i) begin
		if (rd_q) begin
			check(cpu_rdata_o, exp_q.pop_front());
		end
	end

	initial begin
		repeat (2000) @(posedge clk_i);
		fails++;
		report_and_stop();
	end

	initial begin
		void'($urandom(18));
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		chk_out();
		rd(`ORSC_ADDR_INT_OSC_MODE, `ORSC_RST_INT_OSC_MODE);
		rd(`ORSC_ADDR_MAIN_OSC_CTRL, `ORSC_RST_MAIN_OSC_CTRL);
		idle(20);
		m_st = 1'b1;
		rd(`ORSC_ADDR_INT_OSC_MODE, `ORSC_SET_INT_OSC_MODE);
		chk_out();
		// CPU runs from another clock, fast-clock peripherals idle
		wr(`ORSC_ADDR_INT_OSC_MODE, 8'hFF);
		m_hs = 1'b1;
		m_ls = 1'b1;
		m_st = 1'b0;
		rd(`ORSC_ADDR_INT_OSC_MODE, 8'h03);
		idle(3);
		chk_out();
		wr(`ORSC_ADDR_INT_OSC_MODE, 8'h02);
		m_hs = 1'b0;
		rd(`ORSC_ADDR_INT_OSC_MODE, 8'h02);
		idle(20);
		m_st = 1'b1;
		rd(`ORSC_ADDR_INT_OSC_MODE, 8'h82);
		chk_out();
		wr(`ORSC_ADDR_INT_OSC_MODE, 8'h00);
		m_ls = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			ext_clk_mode_i <= i[1];
			m_ms = i[0];
			// Source halt bit and pin mode step through all four combinations
			wr(`ORSC_ADDR_MAIN_OSC_CTRL, {i[0], 7'($urandom)});
			rd(`ORSC_ADDR_MAIN_OSC_CTRL, {i[0], 7'h00});
			idle(3);
			chk_out();
		end
		wr(16'h1234, 8'($urandom));
		rd(16'h1234, `ORSC_READ_UNMAPPED);
		idle(3);
		report_and_stop();
	end
endmodule // orsc_run_stop_ctrl_tb
